/* tdp_cfg.svh */
// constants for the tec driver protection sequencer
`ifndef TDP_CFG_SVH
`define TDP_CFG_SVH
`define TDP_CLK_MHZ      100
`define TDP_CONFIRM_US   100
`define TDP_DETECT_US    1000
`define TDP_HICCUP_US    15000
`define TDP_RAMP_BASE_US 15000
`define TDP_S1_NUM       11
`define TDP_S1_DEN       19
`define TDP_ADDR_FLOAT   7'h60
`define TDP_ADDR_LOW     7'h21
`define TDP_A_CTRL       8'h00
`define TDP_A_HEAT_I     8'h01
`define TDP_A_COOL_I     8'h02
`define TDP_A_HEAT_V     8'h03
`define TDP_A_COOL_V     8'h04
`define TDP_A_TRIP       8'h05
`define TDP_A_STATUS     8'h09
`define TDP_A_IDENT      8'h0a
`define TDP_CTRL_RST     8'h8c
`define TDP_LIM_RST      8'h00
`define TDP_TRIP_RST     8'h00
`define TDP_B_ON         7
`define TDP_B_CLR        1
`define TDP_B_MON        0
`define TDP_B_EN         7
`define TDP_RAMP_HI      3
`define TDP_RAMP_LO      2
`define TDP_CODE_HI      5
`define TDP_BYTE_BITS    4'h8
`define TDP_ACK_SLOT     4'h9
`endif

/* tdp_pkg.sv */
// types shared by the tec driver protection sequencer
package tdp_pkg;
	// power stage sequencing states
	typedef enum logic [2:0] {
		PS_OFF, PS_SOFT, PS_RUN, PS_HICCUP, PS_DETECT, PS_OVP, PS_OTS
	} tdp_ps_t;
	// i2c target phases
	typedef enum logic [2:0] {
		IC_IDLE, IC_ADDR, IC_PTR, IC_WR, IC_RD
	} tdp_ic_t;
endpackage

/* tdp_top.sv */
// protection sequencer and i2c register file of the tec driver
// Operation
// - linear leg limit: hold it, buck regulates
// - linear second limit: immediate stop, hiccup
// - buck overcurrent confirmed over window, then hiccup
// - six-bit heat and cool current codes
// - each current and voltage clamp acts only when enabled
// - active limit steers buck, not setpoint
// - four two-bit secondary trip selectors
// - three faults start hiccup
// - 15ms discharge, repeat while output high
// - 1ms detection then soft-start or hiccup
// - input overvoltage: off, discharge, restart later
// - overtemperature shutdown with automatic recovery
// - registers reachable regardless of pins
// - target address from strap; host waits
// - ramp duration select, 120ms default
// - clear strobe clears latches, self-resets
// - stage runs only with bit and pins
// - direction field reports live state
// - voltage clamp flag sticky until clear
// - current clamp flag latches on rise
// - power good low in listed cases
// - die heat flags latch until clear
`timescale 1ns/1ps
`include "tdp_cfg.svh"
module tdp_top #(
	parameter int unsigned CONFIRM_CYC   = `TDP_CONFIRM_US * `TDP_CLK_MHZ,
	parameter int unsigned DETECT_CYC    = `TDP_DETECT_US * `TDP_CLK_MHZ,
	parameter int unsigned HICCUP_CYC    = `TDP_HICCUP_US * `TDP_CLK_MHZ,
	parameter int unsigned RAMP_BASE_CYC = `TDP_RAMP_BASE_US * `TDP_CLK_MHZ,
	parameter logic [7:0]  IDENT_VALUE   = 8'h5a // arbitrary value
) (
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       addr_pin_low,
	input  wire logic       enable_pin,
	input  wire logic       shutdown_n_pin,
	input  wire logic       ldo_ilim1_hit,
	input  wire logic       ldo_ilim2_hit,
	input  wire logic       buck_tec_i_clamp_flag_hit,
	input  wire logic       heat_i_hit,
	input  wire logic       cool_i_hit,
	input  wire logic       heat_v_hit,
	input  wire logic       cool_v_hit,
	input  wire logic       v_second_hit,
	input  wire logic       out_above_0v4,
	input  wire logic       detect_fault,
	input  wire logic       vin_ov,
	input  wire logic       die_ot,
	input  wire logic       die_warn,
	input  wire logic       dir_heat,
	input  wire logic       dir_cool,
	output logic            stage_en,
	output logic            discharge_en,
	output logic            detect_reg_en,
	output logic            ldo_hold,
	output logic            buck_from_clamp,
	output logic            power_good,
	output logic            monitor_current,
	output logic [5:0]      heat_i_clamp_code,
	output logic [5:0]      cool_i_clamp_code,
	output logic [5:0]      heat_v_clamp_code,
	output logic [5:0]      cool_v_clamp_code,
	output logic [1:0]      ramp_duration_sel,
	output logic [1:0]      linear_leg_heat_trip_sel,
	output logic [1:0]      linear_leg_cool_trip_sel,
	output logic [1:0]      switch_leg_heat_trip_sel,
	output logic [1:0]      switch_leg_cool_trip_sel
);
	// whole module state, one register
	typedef struct packed {
		logic [7:0]      ctrl;     // control byte, strobe bit stored 0
		logic [7:0]      heat_i;   // heat current clamp
		logic [7:0]      cool_i;   // cool current clamp
		logic [7:0]      heat_v;   // heat voltage clamp
		logic [7:0]      cool_v;   // cool voltage clamp
		logic [7:0]      trip;     // secondary trip selectors
		logic            clr;      // one-cycle clear strobe
		logic            vflag;    // sticky voltage clamp
		logic            iflag;    // sticky current clamp
		logic            iprev;    // current clamp last cycle
		logic            otflag;   // sticky overtemperature
		logic            owflag;   // sticky warning
		tdp_pkg::tdp_ps_t ps;      // power stage state
		logic [24:0]     cnt;      // phase timer
		logic [24:0]     conf;     // buck confirmation timer
		tdp_pkg::tdp_ic_t ic;      // i2c phase
		logic [3:0]      bcnt;     // bit counter
		logic [7:0]      sh;       // receive shift
		logic [7:0]      tx;       // transmit shift
		logic [7:0]      ptr;      // register pointer
		logic            rw;       // read transfer
		logic            oe;       // pulling sda low
		logic            scl_q;    // scl last cycle
		logic            sda_q;    // sda last cycle
		logic            addr_lo;  // captured strap
		logic            addr_ok;  // strap captured
	} tdp_state_t;

	tdp_state_t st_r;
	tdp_state_t st_nxt;

	// ramp total in cycles for a select code
	function automatic logic [24:0] ramp_cyc(input logic [1:0] sel);
		ramp_cyc = 25'(RAMP_BASE_CYC << sel);
	endfunction

	// end of first ramp stage, the rest is the second stage
	function automatic logic [24:0] stage1_cyc(input logic [1:0] sel);
		stage1_cyc = 25'((32'(ramp_cyc(sel)) * `TDP_S1_NUM) / `TDP_S1_DEN);
	endfunction

	// register read mux for a given pointer; unmapped reads as zero
	function automatic logic [7:0] rd_mux(input logic [7:0] p, input tdp_state_t s,
		input logic pg);
		unique case (p)
			`TDP_A_CTRL:   rd_mux = s.ctrl;
			`TDP_A_HEAT_I: rd_mux = s.heat_i;
			`TDP_A_COOL_I: rd_mux = s.cool_i;
			`TDP_A_HEAT_V: rd_mux = s.heat_v;
			`TDP_A_COOL_V: rd_mux = s.cool_v;
			`TDP_A_TRIP:   rd_mux = s.trip;
			// live direction, sticky flags, reserved bit zero
			`TDP_A_STATUS: rd_mux = {dir_heat, dir_cool, s.vflag, s.iflag,
				pg, 1'b0, s.otflag, s.owflag};
			`TDP_A_IDENT:  rd_mux = IDENT_VALUE;
			default:       rd_mux = 8'h00;
		endcase
	endfunction

	// limit activity gated by the enables
	logic i_active;
	logic v_active;
	logic allow;
	logic fault;
	logic buck_conf;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [6:0] my_addr;
	logic [24:0] ramp_total;
	logic [7:0]  rd_here;    // byte at the pointer
	logic [7:0]  rd_ahead;   // byte after it, for burst reads

	assign i_active = (st_r.heat_i[`TDP_B_EN] & heat_i_hit)
		| (st_r.cool_i[`TDP_B_EN] & cool_i_hit);
	assign v_active = (st_r.heat_v[`TDP_B_EN] & heat_v_hit)
		| (st_r.cool_v[`TDP_B_EN] & cool_v_hit);
	// all three gates needed, pins never block the bus
	assign allow = st_r.ctrl[`TDP_B_ON] & enable_pin & shutdown_n_pin;
	assign buck_conf = buck_tec_i_clamp_flag_hit && (st_r.conf >= 25'(CONFIRM_CYC - 1));
	assign fault = ldo_ilim2_hit | buck_conf | v_second_hit;
	assign ramp_total = ramp_cyc(st_r.ctrl[`TDP_RAMP_HI:`TDP_RAMP_LO]);
	assign rd_here = rd_mux(st_r.ptr, st_r, power_good);
	assign rd_ahead = rd_mux(st_r.ptr + 8'h1, st_r, power_good);
	assign my_addr = st_r.addr_lo ? `TDP_ADDR_LOW : `TDP_ADDR_FLOAT;
	assign scl_rise = scl_in & ~st_r.scl_q;
	assign scl_fall = ~scl_in & st_r.scl_q;
	assign start_c = scl_in & st_r.scl_q & st_r.sda_q & ~sda_in;
	assign stop_c = scl_in & st_r.scl_q & ~st_r.sda_q & sda_in;

	// stage drive and steering outputs
	assign stage_en = (st_r.ps == tdp_pkg::PS_SOFT) | (st_r.ps == tdp_pkg::PS_RUN)
		| (st_r.ps == tdp_pkg::PS_DETECT);
	assign discharge_en = ~stage_en;
	assign detect_reg_en = (st_r.ps == tdp_pkg::PS_DETECT);
	assign ldo_hold = stage_en & ldo_ilim1_hit;
	assign buck_from_clamp = stage_en & (ldo_ilim1_hit | i_active | v_active);
	// good once ramp stage one ends, low in off, hiccup, faults
	assign power_good = (st_r.ps == tdp_pkg::PS_RUN)
		| ((st_r.ps == tdp_pkg::PS_SOFT)
		& (st_r.cnt >= stage1_cyc(st_r.ctrl[`TDP_RAMP_HI:`TDP_RAMP_LO])));
	assign monitor_current = st_r.ctrl[`TDP_B_MON];
	assign heat_i_clamp_code = st_r.heat_i[`TDP_CODE_HI:0];
	assign cool_i_clamp_code = st_r.cool_i[`TDP_CODE_HI:0];
	assign heat_v_clamp_code = st_r.heat_v[`TDP_CODE_HI:0];
	assign cool_v_clamp_code = st_r.cool_v[`TDP_CODE_HI:0];
	assign ramp_duration_sel = st_r.ctrl[`TDP_RAMP_HI:`TDP_RAMP_LO];
	assign linear_leg_heat_trip_sel = st_r.trip[7:6];
	assign linear_leg_cool_trip_sel = st_r.trip[5:4];
	assign switch_leg_heat_trip_sel = st_r.trip[3:2];
	assign switch_leg_cool_trip_sel = st_r.trip[1:0];
	assign sda_out = 1'b0;
	assign sda_oe = st_r.oe;

	// next state of everything
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.clr = 1'b0;
		st_nxt.scl_q = scl_in;
		st_nxt.sda_q = sda_in;
		// strap caught on the first cycle after reset
		if (!st_r.addr_ok)
		begin
			st_nxt.addr_lo = addr_pin_low;
			st_nxt.addr_ok = 1'b1;
		end
		// buck confirmation timer restarts when the fault clears
		if (buck_tec_i_clamp_flag_hit && stage_en && !buck_conf)
			st_nxt.conf = st_r.conf + 25'h1;
		else if (!buck_tec_i_clamp_flag_hit || !stage_en)
			st_nxt.conf = 25'h0;
		// sticky flags: set wins over the clear strobe
		st_nxt.iprev = i_active;
		if (st_r.clr)
		begin
			st_nxt.vflag = 1'b0;
			st_nxt.iflag = 1'b0;
			st_nxt.otflag = 1'b0;
			st_nxt.owflag = 1'b0;
		end
		if (v_active)
			st_nxt.vflag = 1'b1;
		if (i_active && !st_r.iprev)
			st_nxt.iflag = 1'b1;
		if (die_ot)
			st_nxt.otflag = 1'b1;
		if (die_warn)
			st_nxt.owflag = 1'b1;
		// power stage sequence
		st_nxt.cnt = st_r.cnt + 25'h1;
		if (die_ot)
		begin
			st_nxt.ps = tdp_pkg::PS_OTS;
			st_nxt.cnt = 25'h0;
		end
		else if (vin_ov)
		begin
			st_nxt.ps = tdp_pkg::PS_OVP;
			st_nxt.cnt = 25'h0;
		end
		else if (!allow)
		begin
			st_nxt.ps = tdp_pkg::PS_OFF;
			st_nxt.cnt = 25'h0;
		end
		else
		begin
			unique case (st_r.ps)
				// restart from a fresh ramp once released
				tdp_pkg::PS_OFF, tdp_pkg::PS_OVP, tdp_pkg::PS_OTS:
				begin
					st_nxt.ps = tdp_pkg::PS_SOFT;
					st_nxt.cnt = 25'h0;
				end
				tdp_pkg::PS_SOFT, tdp_pkg::PS_RUN:
				begin
					if (fault)
					begin
						st_nxt.ps = tdp_pkg::PS_HICCUP;
						st_nxt.cnt = 25'h0;
					end
					else if (st_r.ps == tdp_pkg::PS_SOFT && st_r.cnt >= ramp_total - 25'h1)
					begin
						st_nxt.ps = tdp_pkg::PS_RUN;
						st_nxt.cnt = 25'h0;
					end
					else if (st_r.ps == tdp_pkg::PS_RUN)
						st_nxt.cnt = 25'h0;
				end
				// discharge window, repeats while an output is high
				tdp_pkg::PS_HICCUP:
				begin
					if (st_r.cnt >= 25'(HICCUP_CYC - 1))
					begin
						st_nxt.cnt = 25'h0;
						if (!out_above_0v4)
							st_nxt.ps = tdp_pkg::PS_DETECT;
					end
				end
				// probe at 0.4V before committing to a ramp
				tdp_pkg::PS_DETECT:
				begin
					if (fault || detect_fault)
					begin
						st_nxt.ps = tdp_pkg::PS_HICCUP;
						st_nxt.cnt = 25'h0;
					end
					else if (st_r.cnt >= 25'(DETECT_CYC - 1))
					begin
						st_nxt.ps = tdp_pkg::PS_SOFT;
						st_nxt.cnt = 25'h0;
					end
				end
			endcase
		end
		// i2c target, independent of the stage gates
		if (start_c)
		begin
			st_nxt.ic = tdp_pkg::IC_ADDR;
			st_nxt.bcnt = 4'h0;
			st_nxt.oe = 1'b0;
		end
		else if (stop_c)
		begin
			st_nxt.ic = tdp_pkg::IC_IDLE;
			st_nxt.oe = 1'b0;
		end
		else if (scl_rise && st_r.ic != tdp_pkg::IC_IDLE)
		begin
			// sample data bits; in read the ninth bit is the host ack
			if (st_r.bcnt < `TDP_BYTE_BITS)
				st_nxt.sh = {st_r.sh[6:0], sda_in};
			else if (st_r.ic == tdp_pkg::IC_RD)
				st_nxt.rw = ~sda_in;
			if (st_r.bcnt < `TDP_ACK_SLOT)
				st_nxt.bcnt = st_r.bcnt + 4'h1;
		end
		else if (scl_fall)
		begin
			unique case (st_r.ic)
				tdp_pkg::IC_IDLE:
					st_nxt.oe = 1'b0;
				tdp_pkg::IC_ADDR:
				begin
					if (st_r.bcnt == `TDP_BYTE_BITS)
					begin
						if (st_r.sh[7:1] == my_addr)
						begin
							st_nxt.oe = 1'b1;
							st_nxt.rw = st_r.sh[0];
							st_nxt.bcnt = `TDP_ACK_SLOT;
						end
						else
							st_nxt.ic = tdp_pkg::IC_IDLE;
					end
					else if (st_r.bcnt == `TDP_ACK_SLOT)
					begin
						st_nxt.bcnt = 4'h0;
						if (st_r.rw)
						begin
							st_nxt.ic = tdp_pkg::IC_RD;
							st_nxt.tx = rd_here;
							st_nxt.oe = ~rd_here[7];
						end
						else
						begin
							st_nxt.ic = tdp_pkg::IC_PTR;
							st_nxt.oe = 1'b0;
						end
					end
				end
				tdp_pkg::IC_PTR, tdp_pkg::IC_WR:
				begin
					if (st_r.bcnt == `TDP_BYTE_BITS)
					begin
						st_nxt.oe = 1'b1;
						st_nxt.bcnt = `TDP_ACK_SLOT;
						if (st_r.ic == tdp_pkg::IC_PTR)
							st_nxt.ptr = st_r.sh;
						else
						begin
							st_nxt.ptr = st_r.ptr + 8'h1;
							unique case (st_r.ptr)
								`TDP_A_CTRL:
								begin
									// strobe bit never stored, reads 0
									st_nxt.ctrl = st_r.sh & ~(8'h01 << `TDP_B_CLR);
									st_nxt.clr = st_r.sh[`TDP_B_CLR];
								end
								`TDP_A_HEAT_I: st_nxt.heat_i = st_r.sh;
								`TDP_A_COOL_I: st_nxt.cool_i = st_r.sh;
								`TDP_A_HEAT_V: st_nxt.heat_v = st_r.sh;
								`TDP_A_COOL_V: st_nxt.cool_v = st_r.sh;
								`TDP_A_TRIP:   st_nxt.trip = st_r.sh;
								default:       st_nxt.ptr = st_r.ptr + 8'h1;
							endcase
						end
					end
					else if (st_r.bcnt == `TDP_ACK_SLOT)
					begin
						st_nxt.oe = 1'b0;
						st_nxt.bcnt = 4'h0;
						st_nxt.ic = tdp_pkg::IC_WR;
					end
				end
				tdp_pkg::IC_RD:
				begin
					if (st_r.bcnt == `TDP_BYTE_BITS)
						st_nxt.oe = 1'b0;
					else if (st_r.bcnt == `TDP_ACK_SLOT)
					begin
						st_nxt.bcnt = 4'h0;
						if (!st_r.rw)
							st_nxt.ic = tdp_pkg::IC_IDLE;
						else
						begin
							// host acked: next byte must lead on this very fall
							st_nxt.ptr = st_r.ptr + 8'h1;
							st_nxt.tx = rd_ahead;
							st_nxt.oe = ~rd_ahead[7];
						end
					end
					else if (st_r.bcnt != 4'h0)
					begin
						st_nxt.tx = {st_r.tx[6:0], 1'b0};
						st_nxt.oe = ~st_r.tx[6];
					end
				end
			endcase
		end
	end

	// single state register; reset values are constants only
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			st_r <= '0;
			st_r.ctrl <= `TDP_CTRL_RST;
			st_r.heat_i <= `TDP_LIM_RST;
			st_r.cool_i <= `TDP_LIM_RST;
			st_r.heat_v <= `TDP_LIM_RST;
			st_r.cool_v <= `TDP_LIM_RST;
			st_r.trip <= `TDP_TRIP_RST;
			st_r.ps <= tdp_pkg::PS_OFF;
			st_r.ic <= tdp_pkg::IC_IDLE;
			st_r.scl_q <= 1'b1;
			st_r.sda_q <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	// second limit stops the stage the very next cycle
	sequence s_running;
		stage_en && !die_ot && !vin_ov && allow;
	endsequence
	a_ldo_trip_stop: assert property (@(posedge core_clk) disable iff (srst)
		s_running ##0 ldo_ilim2_hit |=> st_r.ps == tdp_pkg::PS_HICCUP)
		else $error("linear second limit did not stop stage");
	a_buck_confirm: assert property (@(posedge core_clk) disable iff (srst)
		$rose(buck_tec_i_clamp_flag_hit) && st_r.ps == tdp_pkg::PS_RUN |=> stage_en)
		else $error("buck fault acted before confirmation");
	a_clamp_gate: assert property (@(posedge core_clk) disable iff (srst)
		buck_from_clamp |-> stage_en && (ldo_ilim1_hit || i_active || v_active))
		else $error("buck steered with no active limit");
	a_hiccup_off: assert property (@(posedge core_clk) disable iff (srst)
		st_r.ps == tdp_pkg::PS_HICCUP |-> !stage_en && discharge_en)
		else $error("stage on during hiccup discharge");
	a_stage_gate: assert property (@(posedge core_clk) disable iff (srst)
		!allow |=> !stage_en)
		else $error("stage ran without all gates high");
	a_over_temp: assert property (@(posedge core_clk) disable iff (srst)
		die_ot |=> st_r.ps == tdp_pkg::PS_OTS && st_r.otflag && !power_good)
		else $error("overtemperature not handled");
	a_strobe_self: assert property (@(posedge core_clk) disable iff (srst)
		st_r.clr |=> !st_r.clr && !st_r.ctrl[`TDP_B_CLR])
		else $error("clear strobe did not return to zero");
	sequence s_vclamp;
		v_active ##1 !v_active;
	endsequence
	a_vflag_sticky: assert property (@(posedge core_clk) disable iff (srst)
		s_vclamp ##0 !st_r.clr |=> st_r.vflag)
		else $error("voltage clamp flag dropped early");
	a_iflag_rise: assert property (@(posedge core_clk) disable iff (srst)
		i_active && !st_r.iprev |=> st_r.iflag)
		else $error("current clamp flag missed rise");
	a_ovp_off: assert property (@(posedge core_clk) disable iff (srst)
		vin_ov |=> !stage_en && discharge_en && !power_good)
		else $error("stage on during input overvoltage");
endmodule

/* tdp_host.sv */
// i2c host model that configures and polls the tec driver
`timescale 1ns/1ps
`include "tdp_cfg.svh"
module tdp_host #(
	parameter logic [6:0]  DEV       = `TDP_ADDR_FLOAT, // target address, strap floating
	parameter int unsigned PWRUP_CYC = 20              // shortened power-up wait
) (
	input  wire logic core_clk,
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda_line
);
	int unsigned hp = 3; // scl half period in clocks, never below 3

	// idle bus: both lines left to the pull-ups
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// every line change lands just after a clock edge
	task tick(input int unsigned n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// no addressing before the target has read its strap
	task power_up_wait;
		tick(PWRUP_CYC);
	endtask

	// start or repeated start: sda falls while scl is high
	task start;
		sda_pull = 1'b0;
		tick(hp);
		scl = 1'b1;
		tick(hp);
		sda_pull = 1'b1;
		tick(hp);
		scl = 1'b0;
		tick(1);
	endtask

	// stop: sda rises while scl is high
	task stop;
		sda_pull = 1'b1;
		tick(hp);
		scl = 1'b1;
		tick(hp);
		sda_pull = 1'b0;
		tick(hp);
	endtask

	// data set while scl is low, sampled late in the high phase
	task bit_io(input logic b, output logic r);
		sda_pull = ~b;
		tick(hp - 1);
		scl = 1'b1;
		tick(hp - 1);
		r = sda_line;
		tick(1);
		scl = 1'b0;
		tick(1);
	endtask

	// byte out msb first, then the target's acknowledge slot
	task wbyte(input logic [7:0] b, output logic ok);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		ok = ~r;
	endtask

	// byte in msb first; the last byte is not acknowledged
	task rbyte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, b[i]);
		bit_io(last, r);
	endtask

	// address only, to see whether anybody answers
	task probe(input logic [6:0] a7, output logic ok);
		start();
		wbyte({a7, 1'b0}, ok);
		stop();
	endtask

	// pointer then data; the target advances the pointer itself
	task wr_regs(input logic [7:0] p, input logic [7:0] d[$], output logic ok);
		logic a;
		start();
		wbyte({DEV, 1'b0}, ok);
		wbyte(p, a);
		foreach (d[i])
			wbyte(d[i], a);
		stop();
	endtask

	// pointer write, repeated start, then n bytes read back
	task rd_regs(input logic [7:0] p, input int n, output logic [7:0] q[$], output logic ok);
		logic       a;
		logic [7:0] b;
		q = {};
		start();
		wbyte({DEV, 1'b0}, ok);
		wbyte(p, a);
		start();
		wbyte({DEV, 1'b1}, a);
		for (int i = 0; i < n; i++)
		begin
			rbyte(i == n - 1, b);
			q.push_back(b);
		end
		stop();
	endtask
endmodule

/* testbench.sv */
// self-checking testbench for the tec driver protection sequencer
`timescale 1ns/1ps
`include "tdp_cfg.svh"
module testbench;
	localparam int         CONF  = 20;        // shortened confirmation window
	localparam int         DET   = 30;        // shortened detection window
	localparam int         HIC   = 50;        // shortened discharge window
	localparam int         RAMP  = 40;        // shortened shortest ramp
	localparam int         PG    = 3;         // positions inside obs
	localparam int         DT    = 1;
	localparam logic [4:0] STEER = 5'b10110;  // which hits steer the buck leg

	logic       core_clk, srst, addr_pin_low, enable_pin, shutdown_n_pin, ok;
	logic       buck_tec_i_clamp_flag_hit, out_above_0v4, detect_fault, die_warn, dir_heat, dir_cool;
	logic [4:0] hits;  // ldo first limit, heat i, cool i, heat v, cool v
	logic [1:0] trip;  // secondary voltage limit, ldo second limit
	logic [1:0] prot;  // die overtemperature, input overvoltage
	logic       sda_oe, stage_en, discharge_en, detect_reg_en, ldo_hold, buck_from_clamp;
	logic       power_good, monitor_current, sda_out;
	logic [5:0] heat_i_clamp_code, cool_i_clamp_code, heat_v_clamp_code, cool_v_clamp_code;
	logic [1:0] ramp_duration_sel, linear_leg_heat_trip_sel, linear_leg_cool_trip_sel;
	logic [1:0] switch_leg_heat_trip_sel, switch_leg_cool_trip_sel;
	wire        scl, sda_pull;
	wire        sda_line = ~(sda_pull | (sda_oe & ~sda_out)); // open drain with pull-up
	wire  [3:0] obs = {power_good, stage_en, detect_reg_en, discharge_en};
	int         err_count, samples_checked;

	// ident value is arbitrary
	tdp_top #(.CONFIRM_CYC(CONF), .DETECT_CYC(DET), .HICCUP_CYC(HIC), .RAMP_BASE_CYC(RAMP),
		.IDENT_VALUE(8'h3c)) uut (
		.core_clk, .srst, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe, .addr_pin_low,
		.enable_pin, .shutdown_n_pin, .ldo_ilim1_hit(hits[4]), .ldo_ilim2_hit(trip[0]),
		.buck_tec_i_clamp_flag_hit, .heat_i_hit(hits[3]), .cool_i_hit(hits[2]), .heat_v_hit(hits[1]),
		.cool_v_hit(hits[0]), .v_second_hit(trip[1]), .out_above_0v4, .detect_fault,
		.vin_ov(prot[0]), .die_ot(prot[1]), .die_warn, .dir_heat, .dir_cool, .stage_en,
		.discharge_en, .detect_reg_en, .ldo_hold, .buck_from_clamp, .power_good,
		.monitor_current, .heat_i_clamp_code, .cool_i_clamp_code, .heat_v_clamp_code,
		.cool_v_clamp_code, .ramp_duration_sel, .linear_leg_heat_trip_sel,
		.linear_leg_cool_trip_sel, .switch_leg_heat_trip_sel, .switch_leg_cool_trip_sel);

	tdp_host host (.core_clk, .scl, .sda_pull, .sda_line);

	// 100 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// single value compare, unknowns never match
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// inputs always move just after the rising edge
	task step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task wr(input logic [7:0] p, input logic [7:0] d[$]);
		host.wr_regs(p, d, ok);
		chk("write ack", 16'h1, {15'h0, ok});
	endtask

	// masked compare of consecutive registers from p on
	task rd_chk(input logic [7:0] p, input logic [7:0] e[$], input logic [7:0] m);
		logic [7:0] q[$];
		host.rd_regs(p, e.size(), q, ok);
		chk("read ack", 16'h1, {15'h0, ok});
		foreach (e[i])
			chk($sformatf("reg %h byte %0d", p, i), {8'h0, e[i] & m}, {8'h0, q[i] & m});
	endtask

	// bounded wait on one observed output
	task wait_obs(input int b, input logic v, input int max);
		int n;
		n = 0;
		while (obs[b] !== v && n < max)
		begin
			step(1);
			n++;
		end
		chk($sformatf("obs bit %0d", b), {15'h0, v}, {15'h0, obs[b]});
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// hang guard, a few times the expected run length
	initial
	begin
		repeat (40000) @(posedge core_clk);
		err_count++;
		end_sim;
	end

	// main sequence
	initial
	begin
		{srst, addr_pin_low, enable_pin, shutdown_n_pin, buck_tec_i_clamp_flag_hit} = 5'b10000;
		{out_above_0v4, detect_fault, die_warn, dir_heat, dir_cool} = 5'b00000;
		{hits, trip, prot} = 9'h000;
		err_count = 0;
		samples_checked = 0;
		step(8);
		srst = 1'b0;
		host.power_up_wait();
		chk("idle stage", 16'h0, {14'h0, stage_en, power_good});
		host.probe(`TDP_ADDR_LOW, ok);
		chk("other address", 16'h0, {15'h0, ok});
		host.probe(`TDP_ADDR_FLOAT, ok);
		chk("own address", 16'h1, {15'h0, ok});
		rd_chk(8'h00, {8'h8c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 8'hff);
		chk("ramp default", 16'h3, {14'h0, ramp_duration_sel});
		wr(8'h09, {8'hff});
		rd_chk(8'h09, {8'h00, 8'h3c}, 8'hff);
		// boundary codes, enables mixed, all four selectors distinct
		wr(8'h01, {8'h3f, 8'h81, 8'h95, 8'h2a, 8'he4});
		rd_chk(8'h01, {8'h3f, 8'h81, 8'h95, 8'h2a, 8'he4}, 8'hff);
		chk("i codes", 16'h0fc1, {4'h0, heat_i_clamp_code, cool_i_clamp_code});
		chk("v codes", 16'h056a, {4'h0, heat_v_clamp_code, cool_v_clamp_code});
		chk("trip sel", 16'h00e4, {8'h0, linear_leg_heat_trip_sel, linear_leg_cool_trip_sel,
			switch_leg_heat_trip_sel, switch_leg_cool_trip_sel});
		// every ramp length, register access while the pins hold the stage off
		for (int s = 3; s >= 0; s--)
		begin
			{enable_pin, shutdown_n_pin} = 2'b00;
			step(1);
			chk("held off", 16'h0, {15'h0, stage_en});
			wr(8'h00, {8'h81 | 8'(s << 2)});
			chk("ramp and monitor", 16'(s * 2 + 1),
				{13'h0, ramp_duration_sel, monitor_current});
			{enable_pin, shutdown_n_pin} = 2'b11;
			step(1);
			chk("soft start", 16'h2, {14'h0, stage_en, power_good});
			step((RAMP << s) * 11 / 19 - 3);
			chk("early good", 16'h0, {15'h0, power_good});
			step((RAMP << s) * 8 / 19 + 6);
			chk("power good", 16'h1, {15'h0, power_good});
		end
		// one clamp input at a time; disabled clamps must not steer
		for (int i = 0; i < 5; i++)
		begin
			hits = 5'(1 << i);
			step(1);
			chk("steering", {14'h0, i == 4, STEER[i]},
				{14'h0, ldo_hold, buck_from_clamp});
		end
		hits = 5'h00;
		dir_heat = 1'b1;
		host.hp = 12;
		rd_chk(8'h09, {8'hb8}, 8'hff);
		host.hp = 3;
		// clear while both clamps stay active: level flag returns, edge flag does not
		{hits, dir_heat, dir_cool} = 7'b0011001;
		wr(8'h00, {8'h82});
		rd_chk(8'h00, {8'h80}, 8'hff);
		rd_chk(8'h09, {8'h68}, 8'hff);
		hits = 5'h00;
		wr(8'h00, {8'h82});
		rd_chk(8'h09, {8'h48}, 8'hff);
		// buck overcurrent shorter than the window twice, then held
		buck_tec_i_clamp_flag_hit = 1'b1;
		step(CONF - 5);
		chk("buck short", 16'h1, {15'h0, stage_en});
		buck_tec_i_clamp_flag_hit = 1'b0;
		step(1);
		buck_tec_i_clamp_flag_hit = 1'b1;
		step(CONF - 5);
		chk("buck retry", 16'h1, {15'h0, stage_en});
		out_above_0v4 = 1'b1;
		step(10);
		chk("buck hiccup", 16'h1,
			{13'h0, stage_en, power_good, discharge_en});
		buck_tec_i_clamp_flag_hit = 1'b0;
		step(HIC + 10);
		chk("discharge again", 16'h0, {14'h0, stage_en, detect_reg_en});
		out_above_0v4 = 1'b0;
		wait_obs(DT, 1'b1, HIC + 5);
		detect_fault = 1'b1;
		step(1);
		chk("detect fault", 16'h0, {15'h0, detect_reg_en});
		detect_fault = 1'b0;
		wait_obs(DT, 1'b1, HIC + 5);
		wait_obs(DT, 1'b0, DET + 2);
		chk("restart", 16'h2, {14'h0, stage_en, power_good});
		wait_obs(PG, 1'b1, RAMP + 2);
		// immediate faults: ldo second limit, secondary voltage limit
		for (int i = 0; i < 2; i++)
		begin
			trip = 2'(1 << i);
			step(1);
			chk("trip off", 16'h0, {15'h0, stage_en});
			trip = 2'b00;
			wait_obs(PG, 1'b1, HIC + DET + RAMP + 10);
		end
		// input overvoltage, then die overtemperature, warning raised meanwhile
		die_warn = 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			prot = 2'(1 << i);
			step(5);
			chk("protect off", 16'h1,
				{13'h0, stage_en, power_good, discharge_en});
			prot = 2'b00;
			step(2);
			chk("protect release", 16'h1, {15'h0, stage_en});
		end
		die_warn = 1'b0;
		rd_chk(8'h09, {8'h03}, 8'h03);
		wr(8'h00, {8'h82});
		rd_chk(8'h09, {8'h00}, 8'h03);
		wr(8'h00, {8'h00});
		step(1);
		chk("stage bit off", 16'h0, {15'h0, stage_en});
		// second reset with the strap pulled low: other address, stage bit on again so soft start resumes
		addr_pin_low = 1'b1;
		srst = 1'b1;
		step(8);
		srst = 1'b0;
		host.power_up_wait();
		chk("reset restart", 16'h2, {14'h0, stage_en, power_good});
		host.probe(`TDP_ADDR_FLOAT, ok);
		chk("strap low other", 16'h0, {15'h0, ok});
		host.probe(`TDP_ADDR_LOW, ok);
		chk("strap low own", 16'h1, {15'h0, ok});
		end_sim;
	end
endmodule
